// *** design/rsf_irq.sv ***
// Purpose: Sticky event bits with write-one-to-clear and a masked interrupt.
// Assumes: Set and clear strobes are single-cycle.
// Notes: A set in the same cycle as its clear keeps the bit set.
`default_nettype none

module rsf_irq #(
   parameter int unsigned N = 6
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [N-1:0] ev_set,
   input wire logic [N-1:0] ev_clr,
   input wire logic [N-1:0] mask,
   output logic [N-1:0] status,
   output logic irq
);

   logic [N-1:0] stat_ff;
   logic irq_ff;

   initial begin
      if (N < 1 || N > 32) begin
         $error("rsf_irq supports 1 to 32 events");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One sticky bit per event.
   for (genvar i = 0; i < N; i++) begin : g_bit
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            stat_ff[i] <= 1'b0;
         end else if (ev_set[i]) begin
            stat_ff[i] <= 1'b1;
         end else if (ev_clr[i]) begin
            stat_ff[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(stat_ff & mask);
      end
   end

   assign status = stat_ff;
   assign irq = irq_ff;

endmodule : rsf_irq

`default_nettype wire

// *** design/rsf_pkg.sv ***
// Purpose: Shared constants for the reset source flag block.
// Assumes: 200 MHz system clock, APB register access with 32-bit data.
// Notes: Delay figures are plain defaults and may be tuned per product.
`default_nettype none

package rsf_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and timing.
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned T_SRESET_NS = 100;
   localparam int unsigned T_LVR_NS = 120;
   localparam int unsigned T_SRESET_CYC =
      ((T_SRESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1) ? 1 :
      (T_SRESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned T_LVR_CYC =
      ((T_LVR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1) ? 1 :
      (T_LVR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets.
   localparam logic [11:0] OFS_FLAGS = 12'h000;
   localparam logic [11:0] OFS_LVTH = 12'h004;
   localparam logic [11:0] OFS_RSTCTL = 12'h008;
   localparam logic [11:0] OFS_STATUS = 12'h00C;
   localparam logic [11:0] OFS_IRQ_STAT = 12'h010;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h014;

   ////////////////////////////////////////////////////////////////////////////
   // Flag register fields.
   localparam int unsigned FLG_WDOG_CFG = 0;
   localparam int unsigned FLG_VSEL = 1;
   localparam int unsigned FLG_LVR = 2;
   localparam int unsigned FLG_RSTCTL = 3;
   localparam int unsigned FLG_W = 4;
   localparam logic [3:0] FLAGS_POR = 4'h0;

   // Status register fields.
   localparam int unsigned ST_TIMEOUT = 0;
   localparam int unsigned ST_PWRDN = 1;

   ////////////////////////////////////////////////////////////////////////////
   // Threshold and reset control codes.
   localparam logic [7:0] LVTH_POR = 8'h55;
   localparam logic [7:0] LVTH_CODE_A = 8'h55;
   localparam logic [7:0] LVTH_CODE_B = 8'h33;
   localparam logic [7:0] LVTH_CODE_C = 8'h99;
   localparam logic [7:0] LVTH_CODE_D = 8'hAA;
   localparam logic [7:0] RSTCTL_POR = 8'h55;
   localparam logic [7:0] RSTCTL_PIN_IO = 8'h55;
   localparam logic [7:0] RSTCTL_PIN_RST = 8'hAA;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt event bits.
   localparam int unsigned EV_LVR = 0;
   localparam int unsigned EV_VSEL = 1;
   localparam int unsigned EV_RSTCTL = 2;
   localparam int unsigned EV_WDOG_CFG = 3;
   localparam int unsigned EV_WDOG_TO = 4;
   localparam int unsigned EV_USB = 5;
   localparam int unsigned EV_W = 6;

endpackage : rsf_pkg

`default_nettype wire

// *** design/rsf_qual.sv ***
// Purpose: Fires one pulse once a level has stood for a set number of cycles.
// Assumes: Level is synchronous to clk.
// Notes: Fires again only after the level has dropped.
`default_nettype none

module rsf_qual #(
   parameter int unsigned CYCLES = 4
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic level,
   output logic fire
);

   localparam int unsigned CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_ff;
   logic done_ff;
   logic fire_ff;

   initial begin
      if (CYCLES < 1) begin
         $error("rsf_qual needs at least one cycle");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counts while the level stands and fires once on the last cycle.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_ff <= '0;
         done_ff <= 1'b0;
         fire_ff <= 1'b0;
      end else if (!level) begin
         cnt_ff <= '0;
         done_ff <= 1'b0;
         fire_ff <= 1'b0;
      end else begin
         fire_ff <= !done_ff && (cnt_ff == LAST);
         if (cnt_ff == LAST) begin
            done_ff <= 1'b1;
         end else begin
            cnt_ff <= cnt_ff + CW'(1);
         end
      end
   end

   assign fire = fire_ff;

endmodule : rsf_qual

`default_nettype wire

// *** design/rsf_top.sv ***
// Purpose: Reset source flags, reset requests and watchdog time-out flags.
// Assumes: APB slave on the system clock; nrst is the power-on reset.
// Notes: The block asks for device resets; nrst clears it, and its own requests reload RSTCTL and, for a bad threshold code, LVTH.
`default_nettype none

module rsf_top #(
   parameter int unsigned SRESET_CYC = rsf_pkg::T_SRESET_CYC,
   parameter int unsigned LVR_CYC = rsf_pkg::T_LVR_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic supply_low,
   input wire logic sleep_mode,
   input wire logic wdog_timeout,
   input wire logic wdog_cfg_corrupt,
   input wire logic usb_reset_cfg,
   input wire logic halt_enter,
   input wire logic wdog_flag_clear,
   output logic sys_reset_req,
   output logic pc_sp_clear,
   output logic ext_reset_pin_en,
   output logic timeout_status_flag,
   output logic power_down_status_flag,
   output logic irq
);

   initial begin
      if (SRESET_CYC < 1 || SRESET_CYC > 4096) begin
         $error("SRESET_CYC out of range");
      end
      if (LVR_CYC < 1 || LVR_CYC > 4096) begin
         $error("LVR_CYC out of range");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode.
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic acc_done;
   logic wr_en;
   logic lane0;
   logic hit;
   logic [11:0] word_addr;

   assign acc_done = psel && penable && pready_ff;
   assign lane0 = pstrb[0];
   assign word_addr = {paddr[11:2], 2'b00};
   assign wr_en = acc_done && pwrite && lane0;

   always_comb begin
      hit = 1'b0;
      unique case (word_addr)
         rsf_pkg::OFS_FLAGS,
         rsf_pkg::OFS_LVTH,
         rsf_pkg::OFS_RSTCTL,
         rsf_pkg::OFS_STATUS,
         rsf_pkg::OFS_IRQ_STAT,
         rsf_pkg::OFS_IRQ_MASK: begin
            hit = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers and state.
   logic [rsf_pkg::FLG_W-1:0] flags_ff;
   logic [7:0] lvth_ff;
   logic [7:0] rstctl_ff;
   logic timeout_ff;
   logic pwrdn_ff;
   logic [rsf_pkg::EV_W-1:0] irq_mask_ff;
   logic sys_reset_req_ff;
   logic pc_sp_clear_ff;
   logic ext_pin_ff;
   logic usb_cfg_d_ff;

   logic lvth_bad;
   logic rstctl_bad;
   logic lvr_level;
   logic lvr_fire;
   logic vsel_fire;
   logic rstctl_fire;
   logic usb_fire;
   logic wdog_run;
   logic wdog_sleep;
   logic full_reset;
   logic [rsf_pkg::EV_W-1:0] ev_set;
   logic [rsf_pkg::EV_W-1:0] ev_clr;
   logic [rsf_pkg::EV_W-1:0] irq_status;
   logic irq_int;

   ////////////////////////////////////////////////////////////////////////////
   // Code checks and event qualification.
   // threshold code check.
   always_comb begin
      unique case (lvth_ff)
         rsf_pkg::LVTH_CODE_A,
         rsf_pkg::LVTH_CODE_B,
         rsf_pkg::LVTH_CODE_C,
         rsf_pkg::LVTH_CODE_D: begin
            lvth_bad = 1'b0;
         end
         default: begin
            lvth_bad = 1'b1;
         end
      endcase
   end

   assign rstctl_bad = (rstctl_ff != rsf_pkg::RSTCTL_PIN_IO) &&
                       (rstctl_ff != rsf_pkg::RSTCTL_PIN_RST);

   assign lvr_level = supply_low && !sleep_mode;

   rsf_qual #(
      .CYCLES(LVR_CYC)
   ) u_lvr_qual (
      .clk(clk),
      .nrst(nrst),
      .level(lvr_level),
      .fire(lvr_fire)
   );

   rsf_qual #(
      .CYCLES(SRESET_CYC)
   ) u_vsel_qual (
      .clk(clk),
      .nrst(nrst),
      .level(lvth_bad),
      .fire(vsel_fire)
   );

   rsf_qual #(
      .CYCLES(SRESET_CYC)
   ) u_rstctl_qual (
      .clk(clk),
      .nrst(nrst),
      .level(rstctl_bad),
      .fire(rstctl_fire)
   );

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         usb_cfg_d_ff <= 1'b0;
      end else begin
         usb_cfg_d_ff <= usb_reset_cfg;
      end
   end

   assign usb_fire = usb_reset_cfg && !usb_cfg_d_ff;
   assign wdog_run = wdog_timeout && !sleep_mode;
   assign wdog_sleep = wdog_timeout && sleep_mode;
   assign full_reset = lvr_fire || vsel_fire || rstctl_fire || usb_fire ||
                       wdog_cfg_corrupt || wdog_run;

   ////////////////////////////////////////////////////////////////////////////
   // Reset requests and reset pin enable.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sys_reset_req_ff <= 1'b0;
      end else begin
         sys_reset_req_ff <= full_reset;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pc_sp_clear_ff <= 1'b0;
      end else begin
         pc_sp_clear_ff <= wdog_sleep && !full_reset;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ext_pin_ff <= 1'b0;
      end else begin
         ext_pin_ff <= (rstctl_ff == rsf_pkg::RSTCTL_PIN_RST);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset source flags.
   // power-on values.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flags_ff <= rsf_pkg::FLAGS_POR;
      end else begin
         for (int i = 0; i < rsf_pkg::FLG_W; i++) begin
            if (wr_en && word_addr == rsf_pkg::OFS_FLAGS && !pwdata[i]) begin
               flags_ff[i] <= 1'b0;
            end
         end
         if (lvr_fire) begin
            flags_ff[rsf_pkg::FLG_LVR] <= 1'b1;
         end
         if (vsel_fire) begin
            flags_ff[rsf_pkg::FLG_VSEL] <= 1'b1;
         end
         if (rstctl_fire) begin
            flags_ff[rsf_pkg::FLG_RSTCTL] <= 1'b1;
         end
         if (wdog_cfg_corrupt) begin
            flags_ff[rsf_pkg::FLG_WDOG_CFG] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Threshold select register.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lvth_ff <= rsf_pkg::LVTH_POR;
      end else if (vsel_fire) begin
         lvth_ff <= rsf_pkg::LVTH_POR;
      end else if (wr_en && word_addr == rsf_pkg::OFS_LVTH) begin
         lvth_ff <= pwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset control register.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstctl_ff <= rsf_pkg::RSTCTL_POR;
      end else if (full_reset) begin
         rstctl_ff <= rsf_pkg::RSTCTL_POR;
      end else if (wr_en && word_addr == rsf_pkg::OFS_RSTCTL) begin
         rstctl_ff <= pwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timeout and power-down flags.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         timeout_ff <= 1'b0;
      end else if (wdog_timeout) begin
         timeout_ff <= 1'b1;
      end else if (wdog_flag_clear) begin
         timeout_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pwrdn_ff <= 1'b0;
      end else if (wdog_sleep || halt_enter) begin
         pwrdn_ff <= 1'b1;
      end else if (wdog_flag_clear) begin
         pwrdn_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt events.
   always_comb begin
      ev_set = '0;
      ev_set[rsf_pkg::EV_LVR] = lvr_fire;
      ev_set[rsf_pkg::EV_VSEL] = vsel_fire;
      ev_set[rsf_pkg::EV_RSTCTL] = rstctl_fire;
      ev_set[rsf_pkg::EV_WDOG_CFG] = wdog_cfg_corrupt;
      ev_set[rsf_pkg::EV_WDOG_TO] = wdog_timeout;
      ev_set[rsf_pkg::EV_USB] = usb_fire;
   end

   assign ev_clr = (wr_en && word_addr == rsf_pkg::OFS_IRQ_STAT) ?
                   pwdata[rsf_pkg::EV_W-1:0] : '0;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_mask_ff <= '0;
      end else if (wr_en && word_addr == rsf_pkg::OFS_IRQ_MASK) begin
         irq_mask_ff <= pwdata[rsf_pkg::EV_W-1:0];
      end
   end

   rsf_irq #(
      .N(rsf_pkg::EV_W)
   ) u_irq (
      .clk(clk),
      .nrst(nrst),
      .ev_set(ev_set),
      .ev_clr(ev_clr),
      .mask(irq_mask_ff),
      .status(irq_status),
      .irq(irq_int)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= psel && penable && !pready_ff;
         pslverr_ff <= psel && penable && !pready_ff && !hit;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prdata_ff <= '0;
      end else if (psel && penable && !pready_ff) begin
         prdata_ff <= '0;
         unique case (word_addr)
            rsf_pkg::OFS_FLAGS: begin
               prdata_ff[rsf_pkg::FLG_W-1:0] <= flags_ff;
            end
            rsf_pkg::OFS_LVTH: begin
               prdata_ff[7:0] <= lvth_ff;
            end
            rsf_pkg::OFS_RSTCTL: begin
               prdata_ff[7:0] <= rstctl_ff;
            end
            rsf_pkg::OFS_STATUS: begin
               prdata_ff[rsf_pkg::ST_TIMEOUT] <= timeout_ff;
               prdata_ff[rsf_pkg::ST_PWRDN] <= pwrdn_ff;
            end
            rsf_pkg::OFS_IRQ_STAT: begin
               prdata_ff[rsf_pkg::EV_W-1:0] <= irq_status;
            end
            rsf_pkg::OFS_IRQ_MASK: begin
               prdata_ff[rsf_pkg::EV_W-1:0] <= irq_mask_ff;
            end
            default: begin
               prdata_ff <= '0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign sys_reset_req = sys_reset_req_ff;
   assign pc_sp_clear = pc_sp_clear_ff;
   assign ext_reset_pin_en = ext_pin_ff;
   assign timeout_status_flag = timeout_ff;
   assign power_down_status_flag = pwrdn_ff;
   assign irq = irq_int;

endmodule : rsf_top

`default_nettype wire

// *** verification/rsf_top_bench.sv ***
// Purpose: Self-checking bench for the reset source flag block.
// Assumes: APB master tasks; short delay parameters.
// Notes: Reset request pulses are counted by a monitor.
`default_nettype none

module rsf_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned SR = 4;
   localparam int unsigned LV = 4;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hF;
   logic [3:0] evp = 4'h0;
   logic supply_low = 1'b0;
   logic sleep_mode = 1'b0;
   logic usb_reset_cfg = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, sys_reset_req, pc_sp_clear, ext_reset_pin_en;
   logic timeout_status_flag, power_down_status_flag, irq;
   logic [31:0] q;
   logic e;
   logic [7:0] codes [4] = '{8'h33, 8'h99, 8'hAA, 8'h55};
   int fail_count = 0;
   int checks = 0;
   int n_req = 0;
   int n_warm = 0;

   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (sys_reset_req === 1'b1) n_req <= n_req + 1;
      if (pc_sp_clear === 1'b1) n_warm <= n_warm + 1;
   end

   rsf_top #(.SRESET_CYC(SR), .LVR_CYC(LV)) rsf_top_inst (.clk(clk), .nrst(nrst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .supply_low(supply_low), .sleep_mode(sleep_mode), .wdog_timeout(evp[0]),
      .wdog_cfg_corrupt(evp[1]), .usb_reset_cfg(usb_reset_cfg), .halt_enter(evp[2]),
      .wdog_flag_clear(evp[3]), .sys_reset_req(sys_reset_req), .pc_sp_clear(pc_sp_clear),
      .ext_reset_pin_en(ext_reset_pin_en), .timeout_status_flag(timeout_status_flag),
      .power_down_status_flag(power_down_status_flag), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("counts checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      cmp(what, exp, q);
   endtask : rd

   task automatic pulse(input int i);
      @(posedge clk);
      evp[i] <= 1'b1;
      @(posedge clk);
      evp[i] <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      rd("flags", rsf_pkg::OFS_FLAGS, 32'h00000000);
      rd("status", rsf_pkg::OFS_STATUS, 32'h00000000);
      rd("lvth", rsf_pkg::OFS_LVTH, 32'h00000055);
      rd("rstctl", rsf_pkg::OFS_RSTCTL, 32'h00000055);
      rd("mask", rsf_pkg::OFS_IRQ_MASK, 32'h00000000);
      $display("test reset values done");
      pulse(0);
      rd("status", rsf_pkg::OFS_STATUS, 32'h00000001);
      cmp("req", 32'h1, 32'(n_req));
      pulse(3);
      rd("status", rsf_pkg::OFS_STATUS, 32'h00000000);
      $display("test run time-out done");
      wr(rsf_pkg::OFS_RSTCTL, 32'h000000AA);
      repeat (2) @(posedge clk);
      cmp("pin", 32'h1, {31'h0, ext_reset_pin_en});
      sleep_mode <= 1'b1;
      pulse(0);
      rd("status", rsf_pkg::OFS_STATUS, 32'h00000003);
      cmp("flag outs", 32'h3, {30'h0, power_down_status_flag, timeout_status_flag});
      cmp("warm", 32'h1, 32'(n_warm));
      cmp("req", 32'h1, 32'(n_req));
      rd("rstctl", rsf_pkg::OFS_RSTCTL, 32'h000000AA);
      sleep_mode <= 1'b0;
      $display("test sleep time-out done");
      usb_reset_cfg <= 1'b1;
      repeat (3) @(posedge clk);
      usb_reset_cfg <= 1'b0;
      cmp("req", 32'h2, 32'(n_req));
      rd("status", rsf_pkg::OFS_STATUS, 32'h00000003);
      cmp("pin", 32'h0, {31'h0, ext_reset_pin_en});
      $display("test usb reset done");
      supply_low <= 1'b1;
      repeat (LV - 1) @(posedge clk);
      supply_low <= 1'b0;
      repeat (4) @(posedge clk);
      cmp("req", 32'h2, 32'(n_req));
      supply_low <= 1'b1;
      repeat (LV + 3) @(posedge clk);
      supply_low <= 1'b0;
      cmp("req", 32'h3, 32'(n_req));
      rd("flags", rsf_pkg::OFS_FLAGS, 32'h00000004);
      rd("status", rsf_pkg::OFS_STATUS, 32'h00000003);
      $display("test low supply done");
      for (int i = 0; i < 4; i++) begin
         wr(rsf_pkg::OFS_LVTH, {24'h0, codes[i]});
         rd("lvth", rsf_pkg::OFS_LVTH, {24'h0, codes[i]});
      end
      repeat (SR + 4) @(posedge clk);
      cmp("req", 32'h3, 32'(n_req));
      wr(rsf_pkg::OFS_LVTH, 32'h00000012);
      repeat (SR + 6) @(posedge clk);
      cmp("req", 32'h4, 32'(n_req));
      rd("flags", rsf_pkg::OFS_FLAGS, 32'h00000006);
      rd("lvth", rsf_pkg::OFS_LVTH, 32'h00000055);
      wr(rsf_pkg::OFS_RSTCTL, 32'h00000000);
      repeat (SR + 6) @(posedge clk);
      cmp("req", 32'h5, 32'(n_req));
      rd("flags", rsf_pkg::OFS_FLAGS, 32'h0000000E);
      pulse(1);
      rd("flags", rsf_pkg::OFS_FLAGS, 32'h0000000F);
      $display("test corruption done");
      wr(rsf_pkg::OFS_FLAGS, 32'hFFFFFFF5);
      rd("flags", rsf_pkg::OFS_FLAGS, 32'h00000005);
      wr(rsf_pkg::OFS_FLAGS, 32'h00000000);
      rd("flags", rsf_pkg::OFS_FLAGS, 32'h00000000);
      pulse(3);
      pulse(2);
      rd("status", rsf_pkg::OFS_STATUS, 32'h00000002);
      $display("test clearing done");
      rd("irq stat", rsf_pkg::OFS_IRQ_STAT, 32'h0000003F);
      cmp("irq", 32'h0, {31'h0, irq});
      wr(rsf_pkg::OFS_IRQ_MASK, 32'h00000010);
      repeat (2) @(posedge clk);
      cmp("irq", 32'h1, {31'h0, irq});
      wr(rsf_pkg::OFS_IRQ_STAT, 32'h0000003F);
      repeat (2) @(posedge clk);
      cmp("irq", 32'h0, {31'h0, irq});
      rd("irq stat", rsf_pkg::OFS_IRQ_STAT, 32'h00000000);
      apb(1'b0, 12'h020, 32'h00000000);
      cmp("unmapped data", 32'h0, q);
      cmp("unmapped err", 32'h1, {31'h0, e});
      $display("test interrupt and bus done");
      tally_and_finish();
   end

   initial begin
      #100000;
      fail_count++;
      $display("BAD watchdog expected done seen hang");
      tally_and_finish();
   end
endmodule : rsf_top_bench

bind rsf_top rsf_top_properties #(.LVR_CYC(LVR_CYC)) rsf_top_properties_inst (
   .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .supply_low(supply_low), .sleep_mode(sleep_mode),
   .wdog_timeout(wdog_timeout), .usb_reset_cfg(usb_reset_cfg),
   .wdog_flag_clear(wdog_flag_clear), .sys_reset_req(sys_reset_req),
   .pc_sp_clear(pc_sp_clear), .timeout_status_flag(timeout_status_flag),
   .power_down_status_flag(power_down_status_flag));

`default_nettype wire

// *** verification/rsf_top_properties.sv ***
// Purpose: Concurrent checks on the reset source flag block ports.
// Assumes: One clock domain, nrst asynchronous active low.
// Notes: Attached by bind from the bench top file.
`default_nettype none

module rsf_top_properties #(
   parameter int unsigned LVR_CYC = 4
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic supply_low,
   input wire logic sleep_mode,
   input wire logic wdog_timeout,
   input wire logic usb_reset_cfg,
   input wire logic wdog_flag_clear,
   input wire logic sys_reset_req,
   input wire logic pc_sp_clear,
   input wire logic timeout_status_flag,
   input wire logic power_down_status_flag
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   ////////////////////////////////////////////////////////////////////////////
   // Counts cycles of a low supply seen in run mode.
   logic [7:0] low_cnt_ff;
   logic [7:0] nxt_low_cnt;
   always_comb begin
      nxt_low_cnt = 8'h00;
      if (supply_low && !sleep_mode && low_cnt_ff != 8'hFF) begin
         nxt_low_cnt = low_cnt_ff + 8'h01;
      end else if (supply_low && !sleep_mode) begin
         nxt_low_cnt = low_cnt_ff;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         low_cnt_ff <= 8'h00;
      end else begin
         low_cnt_ff <= nxt_low_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_wd_run;
      wdog_timeout && !sleep_mode;
   endsequence
   sequence s_wd_sleep;
      wdog_timeout && sleep_mode;
   endsequence
   sequence s_first_access;
      psel && penable && !pready;
   endsequence

   property p_wd_run;
      s_wd_run |=> timeout_status_flag && sys_reset_req;
   endproperty
   a_wd_run: assert property (p_wd_run)
      else $error("run mode time-out did not set flag and request reset");
   property p_wd_sleep_flags;
      s_wd_sleep |=> timeout_status_flag && power_down_status_flag;
   endproperty
   a_wd_sleep_flags: assert property (p_wd_sleep_flags)
      else $error("sleep time-out did not set both flags");
   property p_wd_sleep_warm;
      s_wd_sleep |=> pc_sp_clear || sys_reset_req;
   endproperty
   a_wd_sleep_warm: assert property (p_wd_sleep_warm)
      else $error("sleep time-out gave no warm reset");
   property p_warm_cause;
      pc_sp_clear |-> $past(wdog_timeout && sleep_mode);
   endproperty
   a_warm_cause: assert property (p_warm_cause)
      else $error("warm reset without a sleep time-out");
   property p_usb;
      $rose(usb_reset_cfg) |=> sys_reset_req;
   endproperty
   a_usb: assert property (p_usb)
      else $error("usb reset setting gave no device reset");
   property p_to_hold;
      $fell(timeout_status_flag) |-> $past(wdog_flag_clear);
   endproperty
   a_to_hold: assert property (p_to_hold)
      else $error("timeout flag dropped without a clear");
   property p_pd_hold;
      $fell(power_down_status_flag) |-> $past(wdog_flag_clear);
   endproperty
   a_pd_hold: assert property (p_pd_hold)
      else $error("power-down flag dropped without a clear");
   property p_lvr;
      low_cnt_ff == LVR_CYC |-> ##[1:2] sys_reset_req;
   endproperty
   a_lvr: assert property (p_lvr)
      else $error("qualified low supply gave no reset");
   property p_apb_answer;
      s_first_access |=> pready ##1 !pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("apb answer not one cycle after access start");
   property p_err_ready;
      pslverr |-> pready;
   endproperty
   a_err_ready: assert property (p_err_ready)
      else $error("slave error outside an answer");
endmodule : rsf_top_properties

`default_nettype wire
